// *** ethernet_phy_control_regs.sv ***
// transceiver control registers, management register slave and led drive
`include "phy_ctrl_defs.svh"
module ethernet_phy_control_regs #(
  parameter int unsigned STARTUP_CYCLES = `STARTUP_NS / `SYS_CLK_NS,
  parameter int unsigned SRST_CYCLES    = `SOFT_RESET_NS / `SYS_CLK_NS,
  parameter int unsigned FLASH_CYCLES   = `LED_FLASH_NS / `SYS_CLK_NS,
  // identifier values are arbitrary
  parameter logic [15:0] ID_WORD1       = 16'h0A5A,
  parameter logic [15:0] ID_WORD2       = 16'h5C31
) (
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  input  wire logic                        clk_en,
  input  wire logic [5:0]                  host_addr,
  input  wire logic [7:0]                  host_wdata,
  input  wire logic                        host_wr,
  input  wire logic                        host_rd,
  output logic      [7:0]                  host_rdata,
  input  wire logic                        wait_mode,
  input  wire phy_ctrl_pkg::line_status_s  line_in,
  input  wire logic                        mdc,
  input  wire logic                        mdio_in,
  output logic                             mdio_out,
  output logic                             mdio_oe,
  output phy_ctrl_pkg::leds_s              leds,
  output logic                             mii_col,
  output logic                             fast_pll_pd,
  output logic                             slow_pll_pd,
  output logic                             phy_active,
  output logic                             autoneg_run,
  output logic                             isolate_on,
  output logic                             speed_100,
  output logic                             full_duplex,
  output logic                             irq_req
);
  import phy_ctrl_pkg::*;

  line_status_s line_s1_reg;
  line_status_s line_s2_reg;
  line_status_s line_prev_reg;
  logic [1:0]   md_s1_reg;
  logic [1:0]   md_s2_reg;
  logic         mdc_prev_reg;
  logic         mdc_rise;
  logic         mdio_s;

  logic [7:0]   ctrl0_reg;
  logic [4:0]   ctrl1_reg;
  logic         irq_flag_reg;
  logic         ictl_seen_reg;
  logic         en_prev_reg;
  logic         latch_pulse;
  logic         halted;

  logic [15:0]  mctl_reg;
  logic [15:0]  adv_reg;
  logic [15:0]  np_reg;
  logic [15:0]  ictl_reg;
  logic [15:0]  pctl_reg;
  logic [4:0]   maddr_reg;
  logic         ane_latched_reg;
  logic         srst_busy_reg;
  logic [31:0]  srst_cnt_reg;
  logic         srst_start;
  logic [31:0]  start_cnt_reg;
  logic         started_reg;

  mdio_state_e  md_state_reg;
  logic [4:0]   md_cnt_reg;
  logic [11:0]  md_hdr_reg;
  logic [15:0]  md_word_reg;
  logic         md_wr_stb_reg;
  logic         md_ictl_rd_reg;
  logic [15:0]  mii_rd_data;
  logic         md_hit;
  logic         md_is_read;

  logic [1:0]   flash_trig;
  logic [31:0]  flash_cnt_reg [2];
  logic         led_en;
  logic         loop_on;
  logic         irq_rise;
  logic         fast_st;
  logic         slow_st;

  // pins and line status cross into sys_clk through two flops
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      line_s1_reg   <= '0;
      line_s2_reg   <= '0;
      line_prev_reg <= '0;
      md_s1_reg     <= 2'h3;
      md_s2_reg     <= 2'h3;
      mdc_prev_reg  <= 1'b1;
    end else if (clk_en) begin
      line_s1_reg   <= line_in;
      line_s2_reg   <= line_s1_reg;
      line_prev_reg <= line_s2_reg;
      md_s1_reg     <= {mdc, mdio_in};
      md_s2_reg     <= md_s1_reg;
      mdc_prev_reg  <= md_s2_reg[1];
    end
  end

  assign mdc_rise = md_s2_reg[1] & ~mdc_prev_reg;
  assign mdio_s   = md_s2_reg[0];
  assign irq_rise = line_s2_reg.irq_cond & ~line_prev_reg.irq_cond;

  // host register port
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl0_reg <= '0;
      ctrl1_reg <= '0;
    end else if (clk_en && host_wr) begin
      if (host_addr == `OFF_CTRL0)
        ctrl0_reg <= host_wdata & `C0_WR_MASK;
      if (host_addr == `OFF_CTRL1)
        ctrl1_reg <= host_wdata[4:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      host_rdata <= '0;
    end else if (clk_en && host_rd) begin
      unique case (host_addr)
        `OFF_CTRL0:  host_rdata <= ctrl0_reg;
        `OFF_CTRL1:  host_rdata <= {3'h0, ctrl1_reg};
        `OFF_STATUS: host_rdata <= {2'h0, fast_st, slow_st, 3'h0, irq_flag_reg};
        default:     host_rdata <= '0;
      endcase
    end
  end

  // flag clear is armed only by a management read of the interrupt control word
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_flag_reg  <= 1'b0;
      ictl_seen_reg <= 1'b0;
    end else if (clk_en) begin
      if (host_wr && host_addr == `OFF_STATUS && host_wdata[`SR_IRQ_FLAG] && ictl_seen_reg) begin
        irq_flag_reg  <= 1'b0;
        ictl_seen_reg <= 1'b0;
      end
      if (md_ictl_rd_reg)
        ictl_seen_reg <= 1'b1;
      if (irq_rise)
        irq_flag_reg <= 1'b1;
    end
  end

  assign halted  = ctrl0_reg[`C0_WAIT_STOP] & wait_mode;
  assign irq_req = irq_flag_reg & ctrl0_reg[`C0_IRQ_EN] & ~halted;

  always_ff @(posedge sys_clk) begin
    if (srst)
      en_prev_reg <= 1'b0;
    else if (clk_en)
      en_prev_reg <= ctrl0_reg[`C0_ENABLE];
  end

  assign latch_pulse = ctrl0_reg[`C0_ENABLE] & ~en_prev_reg;

  // soft reset runs a fixed count, reset bit reads one meanwhile
  assign srst_start = md_wr_stb_reg && md_hdr_reg[4:0] == `MII_CTRL && md_word_reg[`MC_RESET];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      srst_busy_reg <= 1'b0;
      srst_cnt_reg  <= '0;
    end else if (clk_en) begin
      if (srst_start) begin
        srst_busy_reg <= 1'b1;
        srst_cnt_reg  <= '0;
      end else if (srst_busy_reg) begin
        srst_cnt_reg <= srst_cnt_reg + 32'h1;
        if (srst_cnt_reg == SRST_CYCLES - 1)
          srst_busy_reg <= 1'b0;
      end
    end
  end

  // management registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mctl_reg        <= `MC_DEFAULT;
      adv_reg         <= `ADV_DEFAULT;
      np_reg          <= '0;
      ictl_reg        <= '0;
      pctl_reg        <= '0;
      maddr_reg       <= '0;
      ane_latched_reg <= 1'b0;
    end else if (clk_en) begin
      if (latch_pulse) begin
        ane_latched_reg      <= ~ctrl0_reg[`C0_AUTONEG_DISABLE_DEFAULT];
        mctl_reg[`MC_ANE]    <= ~ctrl0_reg[`C0_AUTONEG_DISABLE_DEFAULT];
        maddr_reg            <= ctrl1_reg;
      end else if (srst_start) begin
        mctl_reg          <= `MC_DEFAULT;
        mctl_reg[`MC_ANE] <= ane_latched_reg;
        adv_reg           <= `ADV_DEFAULT;
        np_reg            <= '0;
        ictl_reg          <= '0;
        pctl_reg          <= '0;
      end else if (md_wr_stb_reg && !srst_busy_reg) begin
        unique case (md_hdr_reg[4:0])
          `MII_CTRL:  mctl_reg  <= md_word_reg;
          `MII_ADV:   adv_reg   <= md_word_reg;
          `MII_NP:    np_reg    <= md_word_reg;
          `MII_ICTL:  ictl_reg  <= md_word_reg;
          `MII_PCTL:  pctl_reg  <= md_word_reg;
          `MII_MADDR: maddr_reg <= md_word_reg[4:0];
          default:    ;
        endcase
      end else if (autoneg_run) begin
        mctl_reg[`MC_RAN] <= 1'b0;
      end
    end
  end

  // read image of the management space; holes read zero
  always_comb begin
    mii_rd_data = '0;
    unique case (md_hdr_reg[4:0])
      `MII_CTRL:  mii_rd_data = {srst_busy_reg, mctl_reg[14:0]};
      `MII_STAT: begin
        mii_rd_data = `STAT_FIXED;
        mii_rd_data[`STAT_LINK]   = line_s2_reg.link_up;
        mii_rd_data[`STAT_ANCOMP] = autoneg_run & line_s2_reg.link_up;
      end
      `MII_ID1:   mii_rd_data = ID_WORD1;
      `MII_ID2:   mii_rd_data = ID_WORD2;
      `MII_ADV:   mii_rd_data = adv_reg;
      `MII_NP:    mii_rd_data = np_reg;
      `MII_ICTL:  mii_rd_data = ictl_reg;
      `MII_PSTAT: mii_rd_data = {13'h0, line_s2_reg.link_up, speed_100, full_duplex};
      `MII_PCTL:  mii_rd_data = pctl_reg;
      `MII_MADDR: mii_rd_data = {11'h0, maddr_reg};
      default:    mii_rd_data = '0;
    endcase
  end

  assign md_hit     = md_hdr_reg[9:5] == maddr_reg;
  assign md_is_read = md_hdr_reg[11:10] == `MD_OP_READ;

  // serial management slave, sampled and driven on mdc rising edges;
  // preamble is optional, so a lone zero after idle ones starts a frame
  // and the master keeps three idle mdc after a soft reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      md_state_reg   <= MD_IDLE;
      md_cnt_reg     <= '0;
      md_hdr_reg     <= '0;
      md_word_reg    <= '0;
      md_wr_stb_reg  <= 1'b0;
      md_ictl_rd_reg <= 1'b0;
      mdio_oe        <= 1'b0;
      mdio_out       <= 1'b0;
    end else if (clk_en) begin
      md_wr_stb_reg  <= 1'b0;
      md_ictl_rd_reg <= 1'b0;
      if (mdc_rise) begin
        unique case (md_state_reg)
          MD_IDLE: begin
            if (!mdio_s)
              md_state_reg <= MD_START;
          end
          MD_START: begin
            md_cnt_reg   <= '0;
            md_state_reg <= mdio_s ? MD_HDR : MD_IDLE;
          end
          MD_HDR: begin
            md_hdr_reg <= {md_hdr_reg[10:0], mdio_s};
            md_cnt_reg <= md_cnt_reg + 5'h1;
            if (md_cnt_reg == `MD_HDR_BITS - 5'h1) begin
              md_cnt_reg   <= '0;
              md_state_reg <= MD_TA;
            end
          end
          MD_TA: begin
            md_cnt_reg <= md_cnt_reg + 5'h1;
            if (md_cnt_reg == 5'h0) begin
              if (md_is_read && md_hit) begin
                mdio_oe        <= 1'b1;
                mdio_out       <= 1'b0;
                md_word_reg    <= mii_rd_data;
                md_ictl_rd_reg <= md_hdr_reg[4:0] == `MII_ICTL;
              end
            end else begin
              mdio_out     <= md_word_reg[15];
              md_word_reg  <= {md_word_reg[14:0], 1'b0};
              md_cnt_reg   <= '0;
              md_state_reg <= MD_DATA;
            end
          end
          MD_DATA: begin
            md_cnt_reg <= md_cnt_reg + 5'h1;
            if (md_is_read) begin
              mdio_out    <= md_word_reg[15];
              md_word_reg <= {md_word_reg[14:0], 1'b0};
            end else begin
              md_word_reg <= {md_word_reg[14:0], mdio_s};
            end
            if (md_cnt_reg == `MD_DATA_LAST) begin
              mdio_oe       <= 1'b0;
              mdio_out      <= 1'b0;
              md_state_reg  <= MD_IDLE;
              md_wr_stb_reg <= !md_is_read && md_hit && md_hdr_reg[11:10] == `MD_OP_WRITE;
            end
          end
          default: md_state_reg <= MD_IDLE;
        endcase
      end
    end
  end

  // start-up delay restarts on every enable rise and after soft reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      start_cnt_reg <= '0;
      started_reg   <= 1'b0;
    end else if (clk_en) begin
      if (!ctrl0_reg[`C0_ENABLE] || latch_pulse || srst_busy_reg) begin
        start_cnt_reg <= '0;
        started_reg   <= 1'b0;
      end else if (!started_reg) begin
        start_cnt_reg <= start_cnt_reg + 32'h1;
        if (start_cnt_reg == STARTUP_CYCLES - 1)
          started_reg <= 1'b1;
      end
    end
  end

  assign phy_active  = ctrl0_reg[`C0_ENABLE] & started_reg & ~halted & ~srst_busy_reg;
  assign autoneg_run = phy_active & mctl_reg[`MC_ANE];
  assign loop_on     = mctl_reg[`MC_LOOP];
  assign isolate_on  = mctl_reg[`MC_ISOL] | loop_on;
  assign speed_100   = mctl_reg[`MC_ANE] ? line_s2_reg.an_speed_100 : mctl_reg[`MC_SPEED];
  assign full_duplex = mctl_reg[`MC_ANE] ? line_s2_reg.an_full_duplex : mctl_reg[`MC_DUPLEX_SELECT];

  // a manual 10 mbit link keeps the 100 mbit clock generator off, and the reverse
  assign fast_pll_pd = ctrl0_reg[`C0_FAST_OFF] | ~phy_active | (~mctl_reg[`MC_ANE] & ~mctl_reg[`MC_SPEED]);
  assign slow_pll_pd = ctrl0_reg[`C0_SLOW_OFF] | ~phy_active | (~mctl_reg[`MC_ANE] & mctl_reg[`MC_SPEED]);
  assign fast_st     = fast_pll_pd;
  assign slow_st     = slow_pll_pd;

  always_comb begin
    if (loop_on)
      mii_col = mctl_reg[`MC_COLTEST] & line_s2_reg.tx_en;
    else
      mii_col = line_s2_reg.collision & ~isolate_on & phy_active;
  end

  // leds: short events are stretched so that a flash is visible
  assign led_en        = ctrl0_reg[`C0_LED_EN];
  assign flash_trig[0] = line_s2_reg.collision & ~full_duplex & ~loop_on;
  assign flash_trig[1] = line_s2_reg.rx_data;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_flash
      always_ff @(posedge sys_clk) begin
        if (srst)
          flash_cnt_reg[i] <= '0;
        else if (clk_en) begin
          if (flash_trig[i] && phy_active)
            flash_cnt_reg[i] <= FLASH_CYCLES;
          else if (flash_cnt_reg[i] != '0)
            flash_cnt_reg[i] <= flash_cnt_reg[i] - 32'h1;
        end
      end
    end
  endgenerate

  assign leds.collision_led = led_en & (flash_cnt_reg[0] != '0);
  assign leds.duplex_led    = led_en & phy_active & full_duplex;
  assign leds.speed_led     = led_en & phy_active & speed_100;
  assign leds.link_led      = led_en & phy_active & line_s2_reg.link_up;
  assign leds.activity_led  = led_en & (flash_cnt_reg[1] != '0);

  a_leds_dark: assert property (@(posedge sys_clk) disable iff (srst)
    !led_en |-> leds == '0) else $error("leds lit while drive disabled");

  a_irq_gated: assert property (@(posedge sys_clk) disable iff (srst)
    irq_req |-> irq_flag_reg && ctrl0_reg[`C0_IRQ_EN] && !halted) else $error("irq without flag and enable");

  a_ane_latch: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && latch_pulse |=> mctl_reg[`MC_ANE] == !$past(ctrl0_reg[`C0_AUTONEG_DISABLE_DEFAULT])) else $error("autoneg not latched");

  a_addr_latch: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && latch_pulse |=> maddr_reg == $past(ctrl1_reg)) else $error("address not latched");

  a_flag_sets: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && irq_rise |=> irq_flag_reg) else $error("interrupt event lost");

  a_srst_bound: assert property (@(posedge sys_clk) disable iff (srst)
    srst_busy_reg |-> srst_cnt_reg < SRST_CYCLES) else $error("soft reset overran");

  a_wait_halt: assert property (@(posedge sys_clk) disable iff (srst)
    ctrl0_reg[`C0_WAIT_STOP] && wait_mode |-> !phy_active && !irq_req) else $error("running in wait");

  a_loop_col: assert property (@(posedge sys_clk) disable iff (srst)
    loop_on && !mctl_reg[`MC_COLTEST] |-> !mii_col && isolate_on) else $error("collision in loopback");

  a_manual_rate: assert property (@(posedge sys_clk) disable iff (srst)
    !mctl_reg[`MC_ANE] |-> speed_100 == mctl_reg[`MC_SPEED]) else $error("manual speed ignored");

  a_pll_off: assert property (@(posedge sys_clk) disable iff (srst)
    ctrl0_reg[`C0_FAST_OFF] |-> fast_pll_pd && fast_st) else $error("fast pll not off");

  a_slow_off: assert property (@(posedge sys_clk) disable iff (srst)
    ctrl0_reg[`C0_SLOW_OFF] |-> slow_pll_pd && slow_st) else $error("slow pll not off");

  a_hole_zero: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && host_rd && host_addr > `OFF_STATUS |=> host_rdata == '0) else $error("reserved read not zero");

endmodule

// *** phy_ctrl_defs.svh ***
// constants of the transceiver control and management register block
`ifndef PHY_CTRL_DEFS_SVH
`define PHY_CTRL_DEFS_SVH
`define SYS_CLK_NS      20
`define STARTUP_NS      100000
`define SOFT_RESET_NS   1300000
`define LED_FLASH_NS    40000000
`define OFF_CTRL0       6'h00
`define OFF_CTRL1       6'h01
`define OFF_STATUS      6'h02
`define C0_ENABLE       7
`define C0_AUTONEG_DISABLE_DEFAULT        6
`define C0_FAST_OFF     5
`define C0_SLOW_OFF     4
`define C0_LED_EN       3
`define C0_WAIT_STOP    2
`define C0_IRQ_EN       0
`define C0_WR_MASK      8'hFD
`define SR_FAST_OFF     5
`define SR_SLOW_OFF     4
`define SR_IRQ_FLAG     0
`define MC_RESET        15
`define MC_LOOP         14
`define MC_SPEED        13
`define MC_ANE          12
`define MC_ISOL         10
`define MC_RAN          9
`define MC_DUPLEX_SELECT         8
`define MC_COLTEST      7
`define MC_DEFAULT      16'h2000
`define MII_CTRL        5'h00
`define MII_STAT        5'h01
`define MII_ID1         5'h02
`define MII_ID2         5'h03
`define MII_ADV         5'h04
`define MII_NP          5'h07
`define MII_ICTL        5'h10
`define MII_PSTAT       5'h11
`define MII_PCTL        5'h12
`define MII_MADDR       5'h15
`define STAT_FIXED      16'h7849
`define STAT_ANCOMP     5
`define STAT_LINK       2
`define ADV_DEFAULT     16'h01E1
`define MD_OP_READ      2'b10
`define MD_OP_WRITE     2'b01
`define MD_HDR_BITS     5'd12
`define MD_DATA_LAST    5'd15
`endif

// *** phy_ctrl_pkg.sv ***
// types shared by the transceiver control block
package phy_ctrl_pkg;
  typedef struct packed {
    logic link_up;
    logic an_speed_100;
    logic an_full_duplex;
    logic collision;
    logic rx_data;
    logic tx_en;
    logic irq_cond;
  } line_status_s;

  typedef struct packed {
    logic collision_led;
    logic duplex_led;
    logic speed_led;
    logic link_led;
    logic activity_led;
  } leds_s;

  typedef enum logic [2:0] {MD_IDLE, MD_START, MD_HDR, MD_TA, MD_DATA} mdio_state_e;
endpackage

// *** mdio_master_model.sv ***
// management controller model: owns mdc and the master side of the mdio line
`include "phy_ctrl_defs.svh"
module mdio_master_model (
  output logic      mdc,
  output logic      mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drive_en;
  logic drive_bit;
  // pulled up: a line that neither end drives reads high, not the last bit
  assign mdio_in = drive_en ? drive_bit : (mdio_oe ? mdio_out : 1'h1);
  initial begin
    mdc = 1'h0;
    drive_en = 1'h0;
    drive_bit = 1'h0;
  end
  // mdc stands still low between frames unless idle clocks it; no preamble is sent
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] bits;
    bits = {2'h1, op, phy, ra, 2'h2, wd};
    rd = 16'h0000;
    #7;
    for (int i = 0; i < 32; i++) begin
      mdc = 1'h0;
      drive_en = (op != `MD_OP_READ) || (i < 14);
      drive_bit = bits[31-i];
      #80;
      if (i >= 16) rd[31-i] = mdio_in;
      mdc = 1'h1;
      #80;
    end
    mdc = 1'h0;
    drive_en = 1'h0;
    #160;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      #80 mdc = 1'h1;
      #80 mdc = 1'h0;
    end
  endtask
endmodule

// *** ethernet_phy_control_regs_bench.sv ***
// self-checking bench for the transceiver control and management block
`include "phy_ctrl_defs.svh"
module ethernet_phy_control_regs_bench;
  import phy_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic         sys_clk;
  logic         srst;
  logic         clk_en;
  logic [5:0]   host_addr;
  logic [7:0]   host_wdata;
  logic         host_wr;
  logic         host_rd;
  logic [7:0]   host_rdata;
  logic         wait_mode;
  line_status_s line_in;
  logic         mdc;
  logic         mdio_in;
  logic         mdio_out;
  logic         mdio_oe;
  leds_s        leds;
  logic         mii_col;
  logic         fast_pll_pd;
  logic         slow_pll_pd;
  logic         phy_active;
  logic         autoneg_run;
  logic         isolate_on;
  logic         speed_100;
  logic         full_duplex;
  logic         irq_req;
  logic [15:0]  md;
  logic [4:0]   pa;
  int           failures = 0;
  int           tests_run = 0;
  ethernet_phy_control_regs #(.STARTUP_CYCLES(8), .SRST_CYCLES(10), .FLASH_CYCLES(4)) u_ethernet_phy_control_regs (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .wait_mode(wait_mode),
    .line_in(line_in), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .leds(leds), .mii_col(mii_col), .fast_pll_pd(fast_pll_pd), .slow_pll_pd(slow_pll_pd),
    .phy_active(phy_active), .autoneg_run(autoneg_run), .isolate_on(isolate_on),
    .speed_100(speed_100), .full_duplex(full_duplex), .irq_req(irq_req));
  mdio_master_model u_mdio_master_model (.mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    host_wr <= 1'h1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge sys_clk);
    host_wr <= 1'h0;
    ticks(1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    host_rd <= 1'h1;
    host_addr <= a;
    @(posedge sys_clk);
    host_rd <= 1'h0;
    #1;
    chk(host_rdata, exp);
  endtask
  task automatic mrd(input logic [4:0] ra, input logic [15:0] exp);
    u_mdio_master_model.frame(`MD_OP_READ, pa, ra, 16'h0000, md);
    chk(md, exp);
  endtask
  task automatic mwr(input logic [4:0] ra, input logic [15:0] d);
    u_mdio_master_model.frame(`MD_OP_WRITE, pa, ra, d, md);
  endtask
  // bounded: a start-up that never ends is a mismatch, not a hang
  task automatic wait_active();
    for (int n = 0; phy_active !== 1'h1; n++) begin
      if (n > 100) begin
        failures++;
        wrap_up();
      end
      ticks(1);
    end
  endtask
  // {collision led, activity led, mii_col} seen while collision and receive pulse
  task automatic flash(input logic [2:0] m, input logic [2:0] e);
    logic [2:0] seen;
    seen = 3'h0;
    @(posedge sys_clk);
    line_in.collision <= 1'h1;
    line_in.rx_data <= 1'h1;
    repeat (12) begin
      ticks(1);
      seen = seen | {leds.collision_led, leds.activity_led, mii_col};
    end
    line_in.collision <= 1'h0;
    line_in.rx_data <= 1'h0;
    ticks(10);
    chk(seen & m, e);
  endtask
  task automatic t_map();
    rd(`OFF_CTRL0, 8'h00);
    rd(`OFF_CTRL1, 8'h00);
    rd(`OFF_STATUS, 8'h30);
    wr(6'h03, 8'hFF);
    wr(6'h2F, 8'hFF);
    rd(6'h03, 8'h00);
    rd(6'h2F, 8'h00);
  endtask
  // a write strobe seen while the clock enable is low must not land
  task automatic t_freeze();
    @(posedge sys_clk);
    clk_en <= 1'h0;
    host_wr <= 1'h1;
    host_addr <= `OFF_CTRL1;
    host_wdata <= 8'h1F;
    @(posedge sys_clk);
    host_wr <= 1'h0;
    clk_en <= 1'h1;
    ticks(1);
    rd(`OFF_CTRL1, 8'h00);
  endtask
  task automatic t_enable();
    wr(`OFF_CTRL1, {3'h0, pa});
    wr(`OFF_CTRL0, 8'hC8);
    chk(phy_active, 1'h0);
    wait_active();
    chk(autoneg_run, 1'h0);
    rd(`OFF_CTRL0, 8'hC8);
    rd(`OFF_STATUS, 8'h10);
    chk({fast_pll_pd, slow_pll_pd}, 2'h1);
    mrd(`MII_MADDR, {11'h000, pa});
    mrd(`MII_CTRL, `MC_DEFAULT);
    wr(`OFF_CTRL1, 8'h09);
    rd(`OFF_CTRL1, 8'h09);
    mrd(`MII_MADDR, {11'h000, pa});
    u_mdio_master_model.frame(`MD_OP_READ, 5'h09, `MII_CTRL, 16'h0000, md);
    chk(md, 16'hFFFF);
    mrd(5'h08, 16'h0000);
    mrd(5'h0F, 16'h0000);
  endtask
  task automatic t_leds();
    @(posedge sys_clk);
    line_in.link_up <= 1'h1;
    line_in.an_full_duplex <= 1'h1;
    ticks(5);
    chk({leds.duplex_led, leds.speed_led, leds.link_led}, 3'h3);
    chk({speed_100, full_duplex}, 2'h2);
    flash(3'h7, 3'h7);
    wr(`OFF_CTRL0, 8'hC0);
    chk(leds, 5'h00);
    flash(3'h7, 3'h1);
    wr(`OFF_CTRL0, 8'hC8);
    mwr(`MII_CTRL, 16'h6000);
    chk(isolate_on, 1'h1);
    flash(3'h5, 3'h0);
    mwr(`MII_CTRL, 16'h6080);
    @(posedge sys_clk);
    line_in.tx_en <= 1'h1;
    ticks(4);
    chk(mii_col, 1'h1);
    @(posedge sys_clk);
    line_in.tx_en <= 1'h0;
    ticks(4);
    chk(mii_col, 1'h0);
  endtask
  task automatic t_modes();
    mwr(`MII_CTRL, 16'h0100);
    chk({speed_100, full_duplex, isolate_on}, 3'h2);
    chk({leds.duplex_led, leds.speed_led}, 2'h2);
    rd(`OFF_STATUS, 8'h20);
    chk({fast_pll_pd, slow_pll_pd}, 2'h2);
    wr(`OFF_CTRL0, 8'hF8);
    chk({fast_pll_pd, slow_pll_pd}, 2'h3);
    rd(`OFF_STATUS, 8'h30);
    wr(`OFF_CTRL0, 8'hC8);
    chk(slow_pll_pd, 1'h0);
  endtask
  task automatic t_irq();
    @(posedge sys_clk);
    line_in.irq_cond <= 1'h1;
    ticks(5);
    rd(`OFF_STATUS, 8'h21);
    chk(irq_req, 1'h0);
    wr(`OFF_CTRL0, 8'hC9);
    chk(irq_req, 1'h1);
    wr(`OFF_CTRL0, 8'hCD);
    wait_mode <= 1'h1;
    ticks(2);
    chk({phy_active, irq_req}, 2'h0);
    wait_mode <= 1'h0;
    wait_active();
    chk(irq_req, 1'h1);
    wr(`OFF_STATUS, 8'h01);
    rd(`OFF_STATUS, 8'h21);
    u_mdio_master_model.frame(`MD_OP_READ, pa, `MII_ICTL, 16'h0000, md);
    wr(`OFF_STATUS, 8'h01);
    rd(`OFF_STATUS, 8'h20);
    chk(irq_req, 1'h0);
    wr(`OFF_CTRL0, 8'hC8);
  endtask
  // soft reset, then autoneg on the next enable rise with the new address
  task automatic t_reset_autoneg();
    mwr(`MII_CTRL, 16'h8000);
    u_mdio_master_model.idle(3);
    wait_active();
    chk({speed_100, full_duplex}, 2'h2);
    wr(`OFF_CTRL0, 8'h08);
    chk(phy_active, 1'h0);
    wr(`OFF_CTRL0, 8'h88);
    wait_active();
    chk(autoneg_run, 1'h1);
    pa = 5'h09;
    mrd(`MII_MADDR, 16'h0009);
    mrd(`MII_CTRL, 16'h3000);
    chk({speed_100, full_duplex}, 2'h1);
    mwr(`MII_CTRL, 16'h1000);
    mrd(`MII_CTRL, 16'h1000);
  endtask
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    srst = 1'h1;
    clk_en = 1'h1;
    host_addr = 6'h00;
    host_wdata = 8'h00;
    host_wr = 1'h0;
    host_rd = 1'h0;
    wait_mode = 1'h0;
    line_in = 7'h00;
    pa = 5'h05;
    repeat (6) @(posedge sys_clk);
    srst <= 1'h0;
    t_map();
    t_freeze();
    t_enable();
    t_leds();
    t_modes();
    t_irq();
    t_reset_autoneg();
    wrap_up();
  end
endmodule
